//--- hw/hft_pkg.sv
// Shared constants and types for the HDLC framer and deframer
package hft_pkg;
  localparam int FIFO_DEPTH = 19;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [7:0] GA_BYTE = 8'h7F;
  localparam logic [7:0] ABORT_BYTE = 8'hFF;
  localparam logic [7:0] ALL_CALL = 8'hFF;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [3:0] STUFF_ONES = 4'h5;
  localparam logic [3:0] FLAG_ONES = 4'h6;
  localparam logic [3:0] ABORT_ONES = 4'h7;
  localparam logic [3:0] IDLE_ONES = 4'hF;
  localparam logic [6:0] FLAG_TAIL_BITS = 7'h07;
  localparam logic [6:0] MIN_FRAME_BITS = 7'h18;
  localparam logic [6:0] FCS_FRAME_BITS = 7'h20;
  localparam logic [1:0] STATUS_HOLD_BITS = 2'h2;
  localparam logic [4:0] DATA_SLOT = 5'h00;
  localparam logic [4:0] CTRL_SLOT = 5'h01;
  localparam logic [7:0] BIT_POS_RESET = 8'hFF;
  localparam logic [1:0] TAG_MIDDLE = 2'h0;
  localparam logic [1:0] TAG_FIRST = 2'h1;
  localparam logic [1:0] TAG_LAST_GOOD = 2'h2;
  localparam logic [1:0] TAG_LAST_BAD = 2'h3;

  typedef enum logic [1:0] {
    FILL_IDLE = 2'b00,
    FILL_FLAG = 2'b01,
    FILL_GA = 2'b10,
    FILL_TRANSP = 2'b11
  } hft_fill_t;

  typedef enum logic [2:0] {
    TX_FILL = 3'b000,
    TX_OPEN = 3'b001,
    TX_DATA = 3'b010,
    TX_FCS_LO = 3'b011,
    TX_FCS_HI = 3'b100,
    TX_CLOSE = 3'b101,
    TX_ABORT = 3'b110
  } hft_tx_state_t;

  typedef struct packed {
    logic abortTag;
    logic eopTag;
    logic [7:0] data;
  } hft_tx_word_t;

  typedef struct packed {
    logic [1:0] tag;
    logic [7:0] data;
  } hft_rx_word_t;
endpackage

//--- hw/hft_fifo.sv
// Byte FIFO with registered read data
`timescale 1ns/1ps
module hft_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 19
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Write side
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  // Read side
  input wire logic rdEn,
  output logic [WIDTH-1:0] rdData,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic wasEmpty;
  wire logic doWr = wrEn && !full;
  wire logic doRd = rdEn && !empty;

  // A word written into an empty FIFO reaches rdData one cycle later, so empty lags by one
  assign empty = count == '0 || wasEmpty;
  assign full = count == FULL_CNT;

  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr] <= wrData;
    end
  end

  // Head word is re-registered every cycle, one cycle behind a pointer move
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      rdData <= '0;
      wasEmpty <= 1'b1;
    end else begin
      rdData <= mem[rdPtr];
      wasEmpty <= count == '0;
      if (doWr) begin
        wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
      end
      if (doWr && !doRd) begin
        count <= count + 1'b1;
      end else if (doRd && !doWr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

//--- hw/hft_framer.sv
// HDLC framer and deframer on a serial time-division line
`timescale 1ns/1ps
module hft_framer (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Line side
  input wire logic serialBitClock,
  input wire logic framePulse,
  input wire logic serialDataIn,
  input wire logic txClockEnableN,
  input wire logic rxClockEnableN,
  output logic serialDataOut,
  output logic serialOutEnable,
  // Configuration
  input wire logic externalTiming,
  input wire logic [3:0] bitsPerFrame,
  input wire logic transmitEnableBit,
  input wire logic receiveEnableBit,
  input wire logic addressMatchEnable,
  input wire hft_pkg::hft_fill_t interframeFillSelect,
  input wire logic controlSlotEnable,
  input wire logic [7:0] controlTxByte,
  input wire logic [7:0] rxAddress,
  // Transmit FIFO
  input wire logic txWrite,
  input wire logic [7:0] txData,
  input wire logic setEndOfPacket,
  input wire logic setFrameAbort,
  output logic endOfPacketTag,
  output logic frameAbortTag,
  output logic txFull,
  output logic txEmpty,
  // Receive FIFO
  input wire logic rxRead,
  output logic [7:0] rxData,
  output logic [1:0] rxTag,
  output logic rxFull,
  output logic rxEmpty,
  // Status
  input wire logic flagClear,
  output logic idleStatus,
  output logic abortFlag,
  output logic goAheadFlag,
  output logic underrunFlag,
  output logic overflowFlag,
  output logic [7:0] controlRxByte
);
  import hft_pkg::*;

  function automatic logic [15:0] crcBit(input logic [15:0] c, input logic b);
    crcBit = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = crcBit(r, d[i]);
    end
    crcByte = r;
  endfunction

  // Line timing: pins pass two flops, a third finds the bit clock edge
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic clkD;
  logic [7:0] bitPos;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      clkD <= 1'b0;
    end else begin
      sync1 <= {rxClockEnableN, txClockEnableN, serialDataIn, framePulse, serialBitClock};
      sync2 <= sync1;
      clkD <= sync2[0];
    end
  end
  wire logic bitTick = sync2[0] && !clkD;
  wire logic [7:0] curPos = sync2[1] ? 8'h00 : bitPos + 8'h01;
  wire logic [4:0] slotNum = curPos[7:3];
  wire logic [2:0] bitInSlot = curPos[2:0];
  wire logic inData = slotNum == DATA_SLOT && {1'b0, bitInSlot} < bitsPerFrame;
  wire logic ctlSlot = bitTick && !externalTiming && slotNum == CTRL_SLOT;
  wire logic txAct = bitTick && (externalTiming ? !sync2[3] : inData);
  wire logic rxAct = bitTick && (externalTiming ? !sync2[4] : inData);
  wire logic rxBitIn = sync2[2];
  wire logic transp = interframeFillSelect == FILL_TRANSP;
  // One bit per frame is unsupported in transparent mode and falls back to bytes
  wire logic shortBpf = !externalTiming && bitsPerFrame >= 4'h2 && bitsPerFrame <= 4'h7;
  wire logic [3:0] tpLen = shortBpf ? bitsPerFrame : BYTE_BITS;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bitPos <= BIT_POS_RESET;
      controlRxByte <= 8'h00;
    end else if (bitTick) begin
      bitPos <= curPos;
      if (ctlSlot) begin
        controlRxByte <= {controlRxByte[6:0], rxBitIn};
      end
    end
  end

  // FIFOs
  hft_tx_word_t txHead;
  hft_rx_word_t rxHead;
  hft_rx_word_t rxWord;
  logic txEmptyInt, txFullInt, rxEmptyInt, rxFullInt, txPopAll, rxWr;
  wire hft_tx_word_t txIn = '{abortTag: frameAbortTag || setFrameAbort,
                              eopTag: endOfPacketTag || setEndOfPacket, data: txData};
  hft_fifo #(.WIDTH($bits(hft_tx_word_t)), .DEPTH(FIFO_DEPTH)) txFifo (
    .mclk(mclk), .resetn(resetn), .wrEn(txWrite), .wrData(txIn), .rdEn(txPopAll),
    .rdData(txHead), .empty(txEmptyInt), .full(txFullInt));
  hft_fifo #(.WIDTH($bits(hft_rx_word_t)), .DEPTH(FIFO_DEPTH)) rxFifo (
    .mclk(mclk), .resetn(resetn), .wrEn(rxWr), .wrData(rxWord), .rdEn(rxRead),
    .rdData(rxHead), .empty(rxEmptyInt), .full(rxFullInt));
  assign rxData = rxHead.data;
  assign rxTag = rxHead.tag;

  // Host-side tag bits; a set in the write cycle still rides on that byte
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      endOfPacketTag <= 1'b0;
      frameAbortTag <= 1'b0;
    end else begin
      endOfPacketTag <= !txWrite && (endOfPacketTag || setEndOfPacket);
      frameAbortTag <= !txWrite && (frameAbortTag || setFrameAbort);
    end
  end

  // Transmitter
  hft_tx_state_t txState, next_state;
  logic [7:0] txSh, next_sh, txHold;
  logic [3:0] txCnt, next_cnt, txOnes;
  logic [15:0] txCrc;
  logic txStuff, next_stuff, txLast, next_last, txPop, underrunEv;
  wire logic txHeadValid = !txEmptyInt;
  wire logic startOk = transmitEnableBit && txHeadValid && interframeFillSelect != FILL_GA;
  wire logic [7:0] fillByte = interframeFillSelect == FILL_FLAG ? FLAG_BYTE :
                              interframeFillSelect == FILL_GA ? GA_BYTE : IDLE_BYTE;
  wire logic txStuffNow = txStuff && txOnes == STUFF_ONES;
  wire logic txBit = txStuffNow ? 1'b0 : txSh[0];
  wire logic [15:0] crcAfter = (txState == TX_DATA && !txStuffNow) ? crcBit(txCrc, txBit) : txCrc;
  wire logic [3:0] next_ones = (!txStuff || !txBit) ? 4'h0 : txOnes + 4'h1;
  wire logic tpLoad = txCnt <= 4'h1;
  wire logic [7:0] tpByte = txHeadValid ? txHead.data : txHold;
  wire logic tpStop = transp && !transmitEnableBit;
  assign txPopAll = txAct && (transp ? tpLoad && txHeadValid && !tpStop : txPop);

  always_comb begin
    next_state = txState;
    next_sh = {1'b1, txSh[7:1]};
    next_cnt = txCnt - 4'h1;
    next_stuff = txStuff;
    next_last = txLast;
    txPop = 1'b0;
    underrunEv = 1'b0;
    if (txStuffNow) begin
      next_sh = txSh;
      next_cnt = txCnt;
      // A zero owed after the last FCS bit goes out ahead of the closing flag only
      next_stuff = txState != TX_CLOSE;
    end else if (txCnt <= 4'h1) begin
      next_cnt = BYTE_BITS;
      case (txState)
        TX_OPEN, TX_DATA: begin
          next_stuff = 1'b0;
          if (txState == TX_DATA && txLast) begin
            next_state = TX_FCS_LO;
            next_sh = ~crcAfter[7:0];
            next_stuff = 1'b1;
          end else if (!txHeadValid) begin
            underrunEv = 1'b1;
            next_state = TX_ABORT;
            next_sh = ABORT_BYTE;
          end else if (txHead.abortTag) begin
            txPop = 1'b1;
            next_state = TX_ABORT;
            next_sh = ABORT_BYTE;
          end else begin
            txPop = 1'b1;
            next_state = TX_DATA;
            next_sh = txHead.data;
            next_stuff = 1'b1;
            next_last = txHead.eopTag;
          end
        end
        TX_FCS_LO: begin
          next_state = TX_FCS_HI;
          next_sh = ~txCrc[15:8];
        end
        TX_FCS_HI: begin
          next_state = TX_CLOSE;
          next_sh = FLAG_BYTE;
          next_stuff = next_ones == STUFF_ONES;
        end
        default: begin
          next_stuff = 1'b0;
          next_state = startOk ? TX_OPEN : TX_FILL;
          next_sh = startOk ? FLAG_BYTE : fillByte;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txState <= TX_FILL;
      txSh <= IDLE_BYTE;
      txHold <= IDLE_BYTE;
      txCnt <= 4'h0;
      txOnes <= 4'h0;
      txStuff <= 1'b0;
      txLast <= 1'b0;
      txCrc <= CRC_PRESET;
    end else if (tpStop) begin
      txState <= TX_FILL;
      txCnt <= 4'h0;
    end else if (txAct && transp) begin
      txStuff <= 1'b0;
      txState <= TX_FILL;
      txSh <= tpLoad ? tpByte : {1'b1, txSh[7:1]};
      txCnt <= tpLoad ? tpLen : txCnt - 4'h1;
      if (tpLoad && txHeadValid) begin
        txHold <= txHead.data;
      end
    end else if (txAct) begin
      txState <= next_state;
      txSh <= next_sh;
      txCnt <= next_cnt;
      txStuff <= next_stuff;
      txLast <= next_last;
      txOnes <= next_ones;
      txCrc <= (txState == TX_OPEN) ? CRC_PRESET : crcAfter;
    end
  end

  // Line output; packets run to their end even when transmit is disabled
  wire logic txDrive = transmitEnableBit || (!transp && txState != TX_FILL);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      serialDataOut <= 1'b1;
      serialOutEnable <= 1'b0;
    end else if (tpStop) begin
      serialOutEnable <= 1'b0;
    end else if (txAct) begin
      serialDataOut <= transp ? txSh[0] : txBit;
      serialOutEnable <= txDrive;
    end else if (ctlSlot && controlSlotEnable) begin
      serialDataOut <= controlTxByte[3'h7 - bitInSlot];
      serialOutEnable <= 1'b1;
    end else if (bitTick) begin
      serialOutEnable <= 1'b0;
    end
  end

  // Receiver
  logic [3:0] rxOnes;
  logic [7:0] rxAcc, b1, b2, pd;
  logic [2:0] accCnt;
  logic [1:0] held;
  logic [6:0] frameBits;
  logic [15:0] rxCrc;
  logic rxSynced, prevFlag, afterAbort, firstPend, rxDrop;
  wire logic rxOn = rxAct && receiveEnableBit && !transp;
  wire logic rxTp = rxAct && receiveEnableBit && transp;
  wire logic [3:0] onesNext = !rxBitIn ? 4'h0 : (rxOnes == IDLE_ONES) ? rxOnes : rxOnes + 4'h1;
  wire logic flagEv = rxOn && !rxBitIn && rxOnes == FLAG_ONES;
  wire logic stuffDel = rxOn && !rxBitIn && rxOnes == STUFF_ONES;
  wire logic abortEv = rxOn && rxBitIn && onesNext == ABORT_ONES;
  wire logic gaEv = abortEv && prevFlag;
  wire logic dataBit = rxOn && rxSynced && !flagEv && !stuffDel && !abortEv;
  wire logic [7:0] newByte = {rxBitIn, rxAcc[7:1]};
  wire logic byteEv = dataBit && accCnt == 3'h7;
  wire logic addrBad = addressMatchEnable && b2 != rxAddress && b2 != ALL_CALL;
  wire logic [15:0] crcEnd = crcByte(crcByte(crcByte(rxCrc, pd), b2), b1);
  wire logic closeOk = flagEv && rxSynced && held == 2'h3;
  wire logic shortFrame = frameBits < MIN_FRAME_BITS + FLAG_TAIL_BITS;
  wire logic badEnd = frameBits < FCS_FRAME_BITS + FLAG_TAIL_BITS || accCnt != 3'h7 ||
                      crcEnd != CRC_GOOD;
  wire logic wrPipe = byteEv && held == 2'h3;
  wire logic wrClose = closeOk && !shortFrame;
  wire logic wrAbort = abortEv && rxSynced && held == 2'h3 && frameBits >= MIN_FRAME_BITS;
  wire logic tpDone = rxTp && {1'b0, accCnt} == tpLen - 4'h1;
  assign rxWr = tpDone || ((wrPipe || wrClose || wrAbort) && !rxDrop);
  wire logic [1:0] endTag = badEnd ? TAG_LAST_BAD : TAG_LAST_GOOD;
  wire logic [1:0] pipeTag = firstPend ? TAG_FIRST : TAG_MIDDLE;
  assign rxWord = '{tag: tpDone ? TAG_MIDDLE : wrClose ? endTag : wrAbort ? TAG_MIDDLE : pipeTag,
                    data: tpDone ? newByte : pd};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxOnes <= 4'h0;
      rxAcc <= 8'h00;
      accCnt <= 3'h0;
      prevFlag <= 1'b0;
      afterAbort <= 1'b0;
      idleStatus <= 1'b0;
    end else if (!receiveEnableBit) begin
      accCnt <= 3'h0;
    end else if (rxTp) begin
      rxAcc <= newByte;
      accCnt <= tpDone ? 3'h0 : accCnt + 3'h1;
    end else if (rxOn) begin
      rxOnes <= onesNext;
      idleStatus <= onesNext == IDLE_ONES;
      prevFlag <= flagEv ? !afterAbort : prevFlag && rxBitIn;
      afterAbort <= abortEv || (afterAbort && !flagEv);
      if (flagEv) begin
        accCnt <= 3'h0;
      end else if (dataBit) begin
        rxAcc <= newByte;
        accCnt <= accCnt + 3'h1;
      end
    end
  end

  // Byte pipeline holds two bytes back so the FCS never reaches the FIFO
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxSynced <= 1'b0;
      held <= 2'h0;
      b1 <= 8'h00;
      b2 <= 8'h00;
      pd <= 8'h00;
      frameBits <= 7'h00;
      firstPend <= 1'b1;
      rxDrop <= 1'b0;
      rxCrc <= CRC_PRESET;
    end else if (rxWr && rxFullInt && !tpDone) begin
      rxSynced <= 1'b0;
    end else if (flagEv) begin
      rxSynced <= 1'b1;
      held <= 2'h0;
      frameBits <= 7'h00;
      firstPend <= 1'b1;
      rxDrop <= 1'b0;
      rxCrc <= CRC_PRESET;
    end else if (abortEv) begin
      rxSynced <= 1'b0;
    end else if (dataBit) begin
      frameBits <= (frameBits == 7'h7F) ? frameBits : frameBits + 7'h01;
      if (byteEv) begin
        b1 <= newByte;
        b2 <= b1;
        pd <= b2;
        held <= (held == 2'h3) ? held : held + 2'h1;
        if (held == 2'h2 && addrBad) begin
          rxDrop <= 1'b1;
        end
        if (wrPipe) begin
          firstPend <= 1'b0;
          rxCrc <= crcByte(rxCrc, pd);
        end
      end
    end
  end

  // Sticky flags: a set in the clear cycle wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      abortFlag <= 1'b0;
      goAheadFlag <= 1'b0;
      underrunFlag <= 1'b0;
      overflowFlag <= 1'b0;
    end else begin
      abortFlag <= (abortEv && !gaEv) || (abortFlag && !flagClear);
      goAheadFlag <= gaEv || (goAheadFlag && !flagClear);
      underrunFlag <= (txAct && !transp && underrunEv) || (underrunFlag && !flagClear);
      overflowFlag <= (rxWr && rxFullInt) || (overflowFlag && !flagClear);
    end
  end

  // FIFO status is frozen while an access settles, as on the line side
  logic [1:0] holdCnt;
  wire logic fifoAccess = txWrite || rxRead || txPopAll || rxWr;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      holdCnt <= 2'h0;
      txFull <= 1'b0;
      txEmpty <= 1'b1;
      rxFull <= 1'b0;
      rxEmpty <= 1'b1;
    end else if (fifoAccess) begin
      holdCnt <= STATUS_HOLD_BITS;
    end else if (holdCnt != 2'h0) begin
      holdCnt <= bitTick ? holdCnt - 2'h1 : holdCnt;
    end else begin
      txFull <= txFullInt;
      txEmpty <= txEmptyInt;
      rxFull <= rxFullInt;
      rxEmpty <= rxEmptyInt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_eop_clear: assert property (txWrite |=> !endOfPacketTag)
    else $error("end-of-packet bit not cleared by write");
  a_abort_clear: assert property (txWrite |=> !frameAbortTag)
    else $error("frame-abort bit not cleared by write");
  a_underrun_abort: assert property (txAct && !transp && underrunEv |=>
    txState == TX_ABORT && txSh == ABORT_BYTE)
    else $error("underrun did not start abort");
  a_ga_holds: assert property (interframeFillSelect == FILL_GA && txState == TX_FILL |=>
    txState == TX_FILL)
    else $error("packet started during go-ahead fill");
  a_transp_stop: assert property (tpStop |=> !serialOutEnable && txCnt == 4'h0)
    else $error("transparent send not stopped");
  a_status_hold: assert property (holdCnt != 2'h0 && !fifoAccess |=>
    $stable(txEmpty) && $stable(rxEmpty))
    else $error("FIFO status changed during hold");
  a_idle_set: assert property (rxOn && rxBitIn && rxOnes == 4'hE |=> idleStatus)
    else $error("idle status not set after fifteen ones");
  a_short_drop: assert property (flagEv && held != 2'h3 |-> !rxWr)
    else $error("short frame written");
  a_addr_drop: assert property (rxDrop && !tpDone |-> !rxWr)
    else $error("write in dropped packet");
  a_overflow_set: assert property (rxWr && rxFullInt |=> overflowFlag)
    else $error("overflow not flagged");
endmodule

//--- test/hft_line_model.sv
// Line-side partner: free-running bit clock, frame pulse and a looped data wire
`timescale 1ns/1ps
module hft_line_model (
  // Framer transmit pins
  input wire logic serialDataOut,
  input wire logic serialOutEnable,
  // Line timing and receive data
  output logic serialBitClock,
  output logic framePulse,
  output logic serialDataIn
);
  logic [4:0] bitCnt;
  logic outBit;
  initial begin
    serialBitClock = 1'h0;
    framePulse = 1'h0;
    serialDataIn = 1'h1;
    bitCnt = 5'h00;
    outBit = 1'h1;
  end
  always #200 serialBitClock = ~serialBitClock;
  // Capture where the output is settled; a released line toggles, never holds
  always @(posedge serialBitClock) outBit <= serialOutEnable ? serialDataOut : ~outBit;
  always @(negedge serialBitClock) begin
    bitCnt <= bitCnt + 5'h01;
    framePulse <= bitCnt == 5'h1F;
    serialDataIn <= outBit;
  end
endmodule

//--- test/tb_hdlc_frame_tx_rx.sv
// Bench: framer looped back to its own receiver through the line model
`timescale 1ns/1ps
module tb_hdlc_frame_tx_rx;
  import hft_pkg::*;
  logic mclk = 1'h0, resetn = 1'h0, externalTiming = 1'h1, controlSlotEnable = 1'h0;
  logic txClockEnableN = 1'h0, rxClockEnableN = 1'h0, flagClear = 1'h0, rxRead = 1'h0;
  logic transmitEnableBit = 1'h0, receiveEnableBit = 1'h0, addressMatchEnable = 1'h0;
  logic txWrite = 1'h0, setEndOfPacket = 1'h0, setFrameAbort = 1'h0;
  logic [3:0] bitsPerFrame = 4'h8;
  logic [7:0] controlTxByte = 8'h00, rxAddress = 8'h00, txData = 8'h00;
  hft_fill_t interframeFillSelect = FILL_IDLE;
  logic serialBitClock, framePulse, serialDataIn, serialDataOut, serialOutEnable;
  logic endOfPacketTag, frameAbortTag, txFull, txEmpty, rxFull, rxEmpty;
  logic idleStatus, abortFlag, goAheadFlag, underrunFlag, overflowFlag;
  logic [7:0] rxData, controlRxByte;
  logic [1:0] rxTag;
  logic [7:0] pkt [6];
  int nErrors = 0, checkCount = 0, seed = 55;
  hft_framer uut (.mclk, .resetn, .serialBitClock, .framePulse, .serialDataIn,
    .txClockEnableN, .rxClockEnableN, .serialDataOut, .serialOutEnable, .externalTiming,
    .bitsPerFrame, .transmitEnableBit, .receiveEnableBit, .addressMatchEnable,
    .interframeFillSelect, .controlSlotEnable, .controlTxByte, .rxAddress, .txWrite,
    .txData, .setEndOfPacket, .setFrameAbort, .endOfPacketTag, .frameAbortTag, .txFull,
    .txEmpty, .rxRead, .rxData, .rxTag, .rxFull, .rxEmpty, .flagClear, .idleStatus,
    .abortFlag, .goAheadFlag, .underrunFlag, .overflowFlag, .controlRxByte);
  hft_line_model line (.serialDataOut, .serialOutEnable, .serialBitClock, .framePulse,
    .serialDataIn);
  always #25 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic testDone;
    $display("Checks %0d, errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // New random payload behind our own address, sticky flags cleared
  task automatic newPkt;
    foreach (pkt[i]) pkt[i] = 8'($random(seed));
    pkt[0] = rxAddress;
    flagClear = 1'h1;
    tick(1);
    flagClear = 1'h0;
  endtask
  // Back to back writes, never more than 19 at a time
  task automatic sendPkt(input int n, input logic eop, input logic abort);
    for (int i = 0; i < n; i++) begin
      txData = pkt[i];
      txWrite = 1'h1;
      setEndOfPacket = eop && i == n - 1;
      setFrameAbort = abort && i == n - 1;
      tick(1);
    end
    {txWrite, setEndOfPacket, setFrameAbort} = 3'h0;
  endtask
  // Reads spaced past the status hold so a stale not-empty is never trusted
  task automatic recvPkt(input int n, input logic [1:0] lastTag);
    for (int i = 0; i < n; i++) begin
      for (int w = 0; w < 3000 && rxEmpty !== 1'h0; w++) tick(1);
      check(rxData, pkt[i]);
      check({6'h00, rxTag},
            {6'h00, i == 0 ? TAG_FIRST : i == n - 1 ? lastTag : TAG_MIDDLE});
      rxRead = 1'h1;
      tick(1);
      rxRead = 1'h0;
      tick(30);
    end
  endtask
  initial begin
    controlTxByte = 8'($random(seed));
    tick(10);
    resetn = 1'h1;
    check({4'h0, txEmpty, rxEmpty, abortFlag, idleStatus}, 8'h0C);
    rxAddress = 8'($random(seed)) & 8'h7F;
    addressMatchEnable = 1'h1;
    tick(1);
    {transmitEnableBit, receiveEnableBit} = 2'h3;
    tick(400);
    check({7'h00, idleStatus}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      newPkt();
      pkt[0] = k == 0 ? rxAddress : k == 1 ? ALL_CALL : rxAddress ^ 8'h01;
      sendPkt(4, 1'h1, 1'h0);
      if (k < 2) recvPkt(4, TAG_LAST_GOOD);
      else begin
        tick(1500);
        check({7'h00, rxEmpty}, 8'h01);
        check({6'h00, goAheadFlag, abortFlag}, 8'h02);
      end
    end
    interframeFillSelect = FILL_GA;
    newPkt();
    sendPkt(4, 1'h1, 1'h0);
    check({7'h00, txEmpty}, 8'h01);
    tick(1500);
    check({6'h00, txEmpty, rxEmpty}, 8'h01);
    interframeFillSelect = FILL_IDLE;
    recvPkt(4, TAG_LAST_GOOD);
    // Two bytes stay held back for the FCS, so an aborted frame loses its last two
    newPkt();
    sendPkt(6, 1'h0, 1'h1);
    recvPkt(3, TAG_MIDDLE);
    check({7'h00, abortFlag}, 8'h01);
    newPkt();
    sendPkt(6, 1'h0, 1'h0);
    recvPkt(4, TAG_MIDDLE);
    check({6'h00, underrunFlag, abortFlag}, 8'h03);
    {setEndOfPacket, setFrameAbort} = 2'h3;
    tick(1);
    {setEndOfPacket, setFrameAbort} = 2'h0;
    check({6'h00, endOfPacketTag, frameAbortTag}, 8'h03);
    txWrite = 1'h1;
    tick(1);
    txWrite = 1'h0;
    check({6'h00, endOfPacketTag, frameAbortTag}, 8'h00);
    testDone();
  end
  initial begin
    #2000000;
    nErrors++;
    testDone();
  end
endmodule
